//--- verilog/nbu_map.svh
`ifndef NBU_MAP_SVH
`define NBU_MAP_SVH

// ==========================================================
// Register offsets
`define NBU_POWER_CONTROL_REG_OFF 8'h87
`define NBU_SCON0_OFF 8'h98
`define NBU_SERIAL_BUFFER_PORT0_OFF 8'h99
`define NBU_NODE_ADDRESS_PORT0_OFF 8'ha9
`define NBU_NODE_ADDRESS_PORT1_OFF 8'haa
`define NBU_ADDRESS_MASK_PORT0_OFF 8'hb9
`define NBU_ADDRESS_MASK_PORT1_OFF 8'hba
`define NBU_SCON1_OFF 8'hc0
`define NBU_SERIAL_BUFFER_PORT1_OFF 8'hc1

// ==========================================================
// Serial control field positions
`define NBU_SC_SM0_FE 7
`define NBU_SC_SM1 6
`define NBU_SC_SM2 5
`define NBU_SC_REN 4
`define NBU_SC_TB8 3
`define NBU_SC_RB8 2
`define NBU_SC_TI 1
`define NBU_SC_RI 0

// ==========================================================
// Power control field positions
`define NBU_PC_DBL0 7
`define NBU_PC_FVS 6
`define NBU_PC_DBL1 5
`define NBU_PC_T2SEL0 4

// ==========================================================
// Reset values
`define NBU_SERIAL_CONTROL_REG_RST 8'h00
`define NBU_POWER_CONTROL_REG_RST 8'h00
`define NBU_NODE_ADDRESS_RST 8'h00
`define NBU_ADDRESS_MASK_RST 8'h00
`define NBU_SERIAL_BUFFER_RST 8'h00
`define NBU_TXSH_RST 11'h7ff

// ==========================================================
// Bit timing counts
`define NBU_DIV_LAST 4'hf
`define NBU_VOTE_A 4'h6
`define NBU_VOTE_B 4'h7
`define NBU_VOTE_C 4'h8
`define NBU_FRAME_BITS 4'hb
`define NBU_NINTH_IDX 4'h9
`define NBU_STOP_IDX 4'ha
`define NBU_PRE_DIV4 2'h3

`endif

//--- verilog/nbu_pkg.sv
`default_nettype none

package nbu_pkg;

  typedef enum logic [1:0] {
    NBU_RX_IDLE = 2'b01,
    NBU_RX_RUN = 2'b10
  } nbu_rx_state_t;

  typedef enum logic [2:0] {
    NBU_TX_IDLE = 3'b001,
    NBU_TX_WAIT = 3'b010,
    NBU_TX_SEND = 3'b100
  } nbu_tx_state_t;

endpackage

`default_nettype wire

//--- verilog/nbu_uart.sv
// ==========================================================
// Operation
// - Frame is start 0, eight data LSB first, ninth bit, stop 1.
// - Buffer write captures the current transmit ninth bit control.
// - Start bit goes out at first divide-by-16 rollover after write.
// - Transmit done flag sets when the stop bit is driven.
// - Start accepted only while enabled; start falling edge begins a character.
// - Mid ninth bit, load buffer and flag if flag clear and mode allows.
// - Otherwise discard character, buffer and ninth bit untouched.
// - After mid stop bit, go back to watching for falling edge.
// - Each bit is a majority vote of three samples.
// - Votes taken on seventh, eighth and ninth divider clocks.
// - Mode 2 divider runs on oscillator over two or four.
// - Mode 3 uses timer rollover; timer 2 only for port 0.
// - Framing error flag sets when stop bit is invalid.
// - Framing error flag stays set until software clears it.
// - View select picks framing flag or mode bit at bit seven.
// - Framing flag and mode bit are separate storage.
// - In address mode, ninth bit one means address; load only on match.
// - Mask zero bits are ignored in the address compare.
// - Broadcast address is node OR mask, zeros don't care.
// - Masks reset to zero so every address matches.
// - Each port has its own node address and mask.
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`include "nbu_map.svh"
`default_nettype none

module nbu_uart (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  // Timer rollover pulses
  input wire logic timer1_rollover,
  input wire logic timer2_rollover,
  // Serial pins
  input wire logic rxd_port0,
  input wire logic rxd_port1,
  output logic txd_port0,
  output logic txd_port1
);

  // ==========================================================
  // Shared power control and prescaler
  logic [7:0] power_control_reg;
  logic [7:0] next_power_control_reg;
  logic [1:0] pre;
  logic [1:0] next_pre;
  logic [7:0] next_bus_rdata;
  logic framing_view_select;
  logic tick_div2;
  logic tick_div4;
  logic [1:0] rxd_v;
  logic [1:0] txd_v;
  logic [7:0] serial_control_reg_view [2];
  logic [7:0] rbuf_v [2];
  logic [7:0] node_address_v [2];
  logic [7:0] address_mask_v [2];

  assign framing_view_select = power_control_reg[`NBU_PC_FVS];
  assign tick_div2 = pre[0];
  assign tick_div4 = (pre == `NBU_PRE_DIV4);
  assign rxd_v = {rxd_port1, rxd_port0};
  assign txd_port0 = txd_v[0];
  assign txd_port1 = txd_v[1];

  always_comb begin
    next_pre = pre + 2'h1;
    next_power_control_reg = power_control_reg;
    if (bus_wr && bus_addr == `NBU_POWER_CONTROL_REG_OFF) begin
      next_power_control_reg = bus_wdata;
    end
    next_bus_rdata = 8'h00;
    if (bus_rd) begin
      case (bus_addr)
        `NBU_POWER_CONTROL_REG_OFF: next_bus_rdata = power_control_reg;
        `NBU_SCON0_OFF: next_bus_rdata = serial_control_reg_view[0];
        `NBU_SCON1_OFF: next_bus_rdata = serial_control_reg_view[1];
        `NBU_SERIAL_BUFFER_PORT0_OFF: next_bus_rdata = rbuf_v[0];
        `NBU_SERIAL_BUFFER_PORT1_OFF: next_bus_rdata = rbuf_v[1];
        `NBU_NODE_ADDRESS_PORT0_OFF: next_bus_rdata = node_address_v[0];
        `NBU_NODE_ADDRESS_PORT1_OFF: next_bus_rdata = node_address_v[1];
        `NBU_ADDRESS_MASK_PORT0_OFF: next_bus_rdata = address_mask_v[0];
        `NBU_ADDRESS_MASK_PORT1_OFF: next_bus_rdata = address_mask_v[1];
        default: next_bus_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pre <= 2'h0;
      power_control_reg <= `NBU_POWER_CONTROL_REG_RST;
      bus_rdata <= 8'h00;
    end else begin
      pre <= next_pre;
      power_control_reg <= next_power_control_reg;
      bus_rdata <= next_bus_rdata;
    end
  end

  // ==========================================================
  // One serial port per loop pass
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_port
      localparam logic [7:0] SERIAL_CONTROL_REG_OFF =
        (g == 0) ? `NBU_SCON0_OFF : `NBU_SCON1_OFF;
      localparam logic [7:0] SERIAL_BUFFER_OFF =
        (g == 0) ? `NBU_SERIAL_BUFFER_PORT0_OFF : `NBU_SERIAL_BUFFER_PORT1_OFF;
      localparam logic [7:0] NODE_ADDRESS_OFF =
        (g == 0) ? `NBU_NODE_ADDRESS_PORT0_OFF : `NBU_NODE_ADDRESS_PORT1_OFF;
      localparam logic [7:0] ADDRESS_MASK_OFF =
        (g == 0) ? `NBU_ADDRESS_MASK_PORT0_OFF : `NBU_ADDRESS_MASK_PORT1_OFF;

      logic [7:0] serial_control_reg;
      logic framing_error_flag;
      logic [7:0] node_address;
      logic [7:0] address_mask;
      logic [7:0] serial_buffer;
      nbu_pkg::nbu_tx_state_t tx_state;
      logic [10:0] tx_sh;
      logic [3:0] tx_bits;
      logic [3:0] tx_div;
      logic txd;
      nbu_pkg::nbu_rx_state_t rx_state;
      logic [3:0] rx_div;
      logic [3:0] rx_idx;
      logic [1:0] votes;
      logic [8:0] rx_sh;
      logic rxd_prev;

      logic [7:0] next_serial_control_reg;
      logic next_framing_error_flag;
      logic [7:0] next_node_address;
      logic [7:0] next_address_mask;
      logic [7:0] next_serial_buffer;
      nbu_pkg::nbu_tx_state_t next_tx_state;
      logic [10:0] next_tx_sh;
      logic [3:0] next_tx_bits;
      logic [3:0] next_tx_div;
      logic next_txd;
      nbu_pkg::nbu_rx_state_t next_rx_state;
      logic [3:0] next_rx_div;
      logic [3:0] next_rx_idx;
      logic [1:0] next_votes;
      logic [8:0] next_rx_sh;

      logic tick;
      logic tx_roll;
      logic voted;
      logic [7:0] rx_byte;
      logic [7:0] bcast;
      logic addr_hit;
      logic load_ok;

      // Mode 3 picks a timer, mode 2 the prescaler
      always_comb begin
        if (serial_control_reg[`NBU_SC_SM1]) begin
          if (g == 0 && power_control_reg[`NBU_PC_T2SEL0]) begin
            tick = timer2_rollover;
          end else begin
            tick = timer1_rollover;
          end
        end else if (power_control_reg[(g == 0) ? `NBU_PC_DBL0
                                                : `NBU_PC_DBL1]) begin
          tick = tick_div2;
        end else begin
          tick = tick_div4;
        end
      end

      assign tx_roll = tick && (tx_div == `NBU_DIV_LAST);
      // Two of three samples decide the bit
      assign voted = (votes[0] & votes[1]) | (votes[0] & rxd_v[g]) |
                     (votes[1] & rxd_v[g]);
      assign rx_byte = rx_sh[8:1];
      assign bcast = node_address | address_mask;
      assign addr_hit =
        (((rx_byte ^ node_address) & address_mask) == 8'h00) ||
        ((rx_byte & bcast) == bcast);
      assign load_ok = !serial_control_reg[`NBU_SC_RI] &&
        (!serial_control_reg[`NBU_SC_SM2] || (voted && addr_hit));

      assign serial_control_reg_view[g] = {framing_view_select ? framing_error_flag
                             : serial_control_reg[`NBU_SC_SM0_FE],
                             serial_control_reg[6:0]};
      assign rbuf_v[g] = serial_buffer;
      assign node_address_v[g] = node_address;
      assign address_mask_v[g] = address_mask;
      assign txd_v[g] = txd;

      always_comb begin
        next_serial_control_reg = serial_control_reg;
        next_framing_error_flag = framing_error_flag;
        next_node_address = node_address;
        next_address_mask = address_mask;
        next_serial_buffer = serial_buffer;
        next_tx_state = tx_state;
        next_tx_sh = tx_sh;
        next_tx_bits = tx_bits;
        next_tx_div = tx_div;
        next_txd = txd;
        next_rx_state = rx_state;
        next_rx_div = rx_div;
        next_rx_idx = rx_idx;
        next_votes = votes;
        next_rx_sh = rx_sh;

        // Software side first, so hardware sets below win
        if (bus_wr && bus_addr == SERIAL_CONTROL_REG_OFF) begin
          next_serial_control_reg[6:0] = bus_wdata[6:0];
          if (framing_view_select) begin
            next_framing_error_flag = bus_wdata[`NBU_SC_SM0_FE];
          end else begin
            next_serial_control_reg[`NBU_SC_SM0_FE] =
              bus_wdata[`NBU_SC_SM0_FE];
          end
        end
        if (bus_wr && bus_addr == NODE_ADDRESS_OFF) begin
          next_node_address = bus_wdata;
        end
        if (bus_wr && bus_addr == ADDRESS_MASK_OFF) begin
          next_address_mask = bus_wdata;
        end

        // ==========================================================
        // Transmitter
        // Divider runs free, so a write waits for the next rollover
        if (tick) begin
          next_tx_div = tx_div + 4'h1;
        end
        case (tx_state)
          nbu_pkg::NBU_TX_IDLE: begin
            next_txd = 1'b1;
          end
          nbu_pkg::NBU_TX_WAIT: begin
            if (tx_roll) begin
              next_txd = tx_sh[0];
              next_tx_sh = {1'b1, tx_sh[10:1]};
              next_tx_bits = 4'h1;
              next_tx_state = nbu_pkg::NBU_TX_SEND;
            end
          end
          nbu_pkg::NBU_TX_SEND: begin
            if (tx_roll) begin
              if (tx_bits == `NBU_FRAME_BITS) begin
                next_txd = 1'b1;
                next_tx_state = nbu_pkg::NBU_TX_IDLE;
              end else begin
                next_txd = tx_sh[0];
                next_tx_sh = {1'b1, tx_sh[10:1]};
                next_tx_bits = tx_bits + 4'h1;
                if (tx_bits == `NBU_STOP_IDX) begin
                  next_serial_control_reg[`NBU_SC_TI] = 1'b1;
                end
              end
            end
          end
          default: begin
            next_tx_state = nbu_pkg::NBU_TX_IDLE;
          end
        endcase
        // A write mid-frame restarts with the new character
        if (bus_wr && bus_addr == SERIAL_BUFFER_OFF) begin
          next_tx_sh = {1'b1, serial_control_reg[`NBU_SC_TB8],
                        bus_wdata, 1'b0};
          next_tx_state = nbu_pkg::NBU_TX_WAIT;
        end

        // ==========================================================
        // Receiver
        case (rx_state)
          nbu_pkg::NBU_RX_IDLE: begin
            // Enable gates the start only; a frame in flight completes
            if (serial_control_reg[`NBU_SC_REN] && rxd_prev &&
                !rxd_v[g]) begin
              next_rx_state = nbu_pkg::NBU_RX_RUN;
              next_rx_div = 4'h0;
              next_rx_idx = 4'h0;
            end
          end
          nbu_pkg::NBU_RX_RUN: begin
            if (tick) begin
              next_rx_div = rx_div + 4'h1;
              // Two stored votes plus the live pin make the third
              if (rx_div == `NBU_VOTE_A) begin
                next_votes[0] = rxd_v[g];
              end
              if (rx_div == `NBU_VOTE_B) begin
                next_votes[1] = rxd_v[g];
              end
              if (rx_div == `NBU_VOTE_C) begin
                next_rx_idx = rx_idx + 4'h1;
                if (rx_idx == 4'h0) begin
                  // A start voted high was noise; rearm the edge detector
                  if (voted) begin
                    next_rx_state = nbu_pkg::NBU_RX_IDLE;
                  end
                end else if (rx_idx == `NBU_STOP_IDX) begin
                  if (!voted) begin
                    next_framing_error_flag = 1'b1;
                  end
                  next_rx_state = nbu_pkg::NBU_RX_IDLE;
                end else begin
                  next_rx_sh = {voted, rx_sh[8:1]};
                  if (rx_idx == `NBU_NINTH_IDX && load_ok) begin
                    next_serial_buffer = rx_byte;
                    next_serial_control_reg[`NBU_SC_RB8] = voted;
                    next_serial_control_reg[`NBU_SC_RI] = 1'b1;
                  end
                end
              end
            end
          end
          default: begin
            next_rx_state = nbu_pkg::NBU_RX_IDLE;
          end
        endcase
      end

      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          serial_control_reg <= `NBU_SERIAL_CONTROL_REG_RST;
          framing_error_flag <= 1'b0;
          node_address <= `NBU_NODE_ADDRESS_RST;
          address_mask <= `NBU_ADDRESS_MASK_RST;
          serial_buffer <= `NBU_SERIAL_BUFFER_RST;
          tx_state <= nbu_pkg::NBU_TX_IDLE;
          tx_sh <= `NBU_TXSH_RST;
          tx_bits <= 4'h0;
          tx_div <= 4'h0;
          txd <= 1'b1;
          rx_state <= nbu_pkg::NBU_RX_IDLE;
          rx_div <= 4'h0;
          rx_idx <= 4'h0;
          votes <= 2'h0;
          rx_sh <= 9'h000;
          rxd_prev <= 1'b1;
        end else begin
          serial_control_reg <= next_serial_control_reg;
          framing_error_flag <= next_framing_error_flag;
          node_address <= next_node_address;
          address_mask <= next_address_mask;
          serial_buffer <= next_serial_buffer;
          tx_state <= next_tx_state;
          tx_sh <= next_tx_sh;
          tx_bits <= next_tx_bits;
          tx_div <= next_tx_div;
          txd <= next_txd;
          rx_state <= next_rx_state;
          rx_div <= next_rx_div;
          rx_idx <= next_rx_idx;
          votes <= next_votes;
          rx_sh <= next_rx_sh;
          rxd_prev <= rxd_v[g];
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

//--- verif/nbu_chk_properties.sv
`timescale 1ns/1ps
`include "nbu_map.svh"
`default_nettype none
// ======================================================
// Port watcher
module nbu_chk (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_rdata,
  // Serial outputs
  input wire logic txd_port0,
  input wire logic txd_port1
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [4:0] run0;
  logic [4:0] next_run0;
  logic txd0_q;
  logic [1:0] seen;
  logic [1:0] next_seen;
  // Saturates so a long idle never wraps into a short count
  always_comb begin
    next_run0 = (txd_port0 != txd0_q) ? 5'h01 : run0 + {4'h0, run0 != 5'h1f};
    next_seen = seen | {bus_wr && bus_addr == `NBU_SERIAL_BUFFER_PORT1_OFF,
                        bus_wr && bus_addr == `NBU_SERIAL_BUFFER_PORT0_OFF};
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      run0 <= 5'h1f;
      txd0_q <= 1'b1;
      seen <= 2'h0;
    end else begin
      run0 <= next_run0;
      txd0_q <= txd_port0;
      seen <= next_seen;
    end
  end
  a_rdata_idle: assert property (!$past(bus_rd) |-> bus_rdata == 8'h00)
    else $error("Read data not zero outside a read answer");
  a_unmapped_zero: assert property (
    bus_rd && bus_addr == 8'h00 |=> bus_rdata == 8'h00)
    else $error("Unmapped read not zero");
  a_node1_readback: assert property (
    bus_wr && bus_addr == 8'haa ##1 bus_rd && bus_addr == 8'haa
    |=> bus_rdata == $past(bus_wdata, 2))
    else $error("Port 1 node address readback wrong");
  a_mask0_readback: assert property (
    bus_wr && bus_addr == 8'hb9 ##1 bus_rd && bus_addr == 8'hb9
    |=> bus_rdata == $past(bus_wdata, 2))
    else $error("Port 0 mask readback wrong");
  a_tx0_quiet: assert property (!seen[0] |-> txd_port0)
    else $error("Port 0 sent without a buffer write");
  a_tx1_quiet: assert property (!seen[1] |-> txd_port1)
    else $error("Port 1 sent without a buffer write");
  a_bit_min_len: assert property ($changed(txd_port0) |-> run0 >= 5'h10)
    else $error("Port 0 bit shorter than sixteen clocks");
  a_start_hold: assert property ($fell(txd_port0) |-> !txd_port0 [*8])
    else $error("Port 0 start bit cut short");
endmodule

bind nbu_uart nbu_chk i_chk (.core_clk(core_clk), .rst_n(rst_n),
  .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
  .bus_rd(bus_rd), .bus_rdata(bus_rdata), .txd_port0(txd_port0),
  .txd_port1(txd_port1));
`default_nettype wire

//--- verif/nbu_remote_node.sv
`timescale 1ns/1ps
`default_nettype none
// ======================================================
// Far node serial port
module nbu_remote_node #(
  parameter int BIT_CLKS = 32
) (
  // Clock
  input wire logic core_clk,
  // Serial lines
  input wire logic txd_in,
  output logic rxd_out
);
  initial rxd_out = 1'b1;
  // A one clock glitch mid bit can spoil only one vote
  task automatic send_frame(input logic [7:0] d, input logic nin,
                            input logic stp, input logic glitch);
    logic [10:0] fr;
    fr = {stp, nin, d, 1'b0};
    for (int b = 0; b < 11; b++) begin
      for (int c = 0; c < BIT_CLKS; c++) begin
        @(posedge core_clk);
        rxd_out <= fr[b] ^ (glitch && b > 0 && b < 10 && c == BIT_CLKS / 2);
      end
    end
    @(posedge core_clk);
    rxd_out <= 1'b1;
  endtask
  task automatic capture_frame(output logic [10:0] fr);
    @(negedge txd_in);
    #1;
    repeat (BIT_CLKS / 2) @(posedge core_clk);
    for (int b = 0; b < 11; b++) begin
      #1 fr[b] = txd_in;
      repeat (BIT_CLKS) @(posedge core_clk);
    end
  endtask
endmodule
`default_nettype wire

//--- verif/tb_top.sv
`timescale 1ns/1ps
`include "nbu_map.svh"
`default_nettype none
// ======================================================
// Bench top
module tb_top;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] bus_addr = 8'h00;
  logic [7:0] bus_wdata = 8'h00;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [7:0] bus_rdata;
  logic timer1_rollover = 1'b0;
  logic timer2_rollover = 1'b0;
  logic rxd_port0, rxd_port1, txd_port0, txd_port1;
  logic [1:0] tdiv = 2'h0;
  logic [10:0] f;
  logic [10:0] fb;
  logic [7:0] d;
  logic [7:0] adr [4] = '{8'hf1, 8'hf2, 8'hff, 8'hf0};
  logic [3:0] nin = 4'b0111;
  logic [3:0] hit = 4'b0101;
  int err_count = 0;
  int total_checks = 0;
  int cycles = 0;
  always #12.5 core_clk = ~core_clk;
  // Timer 1 ticks every fourth clock, timer 2 every second one
  always @(posedge core_clk) begin
    tdiv <= tdiv + 2'h1;
    timer1_rollover <= (tdiv == 2'h3);
    timer2_rollover <= tdiv[0];
  end
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      end_sim();
    end
  end
  nbu_uart i_dut (.core_clk(core_clk), .rst_n(rst_n), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .timer1_rollover(timer1_rollover),
    .timer2_rollover(timer2_rollover), .rxd_port0(rxd_port0),
    .rxd_port1(rxd_port1), .txd_port0(txd_port0), .txd_port1(txd_port1));
  nbu_remote_node #(.BIT_CLKS(32)) i_remote0 (.core_clk(core_clk),
    .txd_in(txd_port0), .rxd_out(rxd_port0));
  nbu_remote_node #(.BIT_CLKS(64)) i_remote1 (.core_clk(core_clk),
    .txd_in(txd_port1), .rxd_out(rxd_port1));
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    bus_addr <= a;
    bus_wdata <= v;
    bus_wr <= 1'b1;
    @(posedge core_clk);
    bus_wr <= 1'b0;
    #1;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] m,
                     input logic [7:0] e);
    logic [7:0] r;
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge core_clk);
    bus_rd <= 1'b0;
    #1 r = bus_rdata;
    chk({3'h0, r & m}, {3'h0, e});
  endtask
  task automatic end_sim();
    $display("Checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    rdc(`NBU_ADDRESS_MASK_PORT0_OFF, 8'hff, 8'h00);
    rdc(`NBU_ADDRESS_MASK_PORT1_OFF, 8'hff, 8'h00);
    wr(8'h00, 8'h5a);
    rdc(8'h00, 8'hff, 8'h00);
    wr(`NBU_NODE_ADDRESS_PORT1_OFF, 8'h3c);
    rdc(`NBU_NODE_ADDRESS_PORT1_OFF, 8'hff, 8'h3c);
    wr(`NBU_ADDRESS_MASK_PORT0_OFF, 8'hfa);
    rdc(`NBU_ADDRESS_MASK_PORT0_OFF, 8'hff, 8'hfa);
    wr(`NBU_NODE_ADDRESS_PORT0_OFF, 8'hf0);
    rdc(`NBU_NODE_ADDRESS_PORT1_OFF, 8'hff, 8'h3c);
    wr(`NBU_POWER_CONTROL_REG_OFF, 8'ha0);
    // Ninth bit control flips after the write; the latched one must go out
    for (int i = 0; i < 2; i++) begin
      d = 8'ha5 ^ {8{i[0]}};
      wr(`NBU_SCON0_OFF, i[0] ? 8'h90 : 8'h98);
      fork
        i_remote0.capture_frame(f);
        begin
          wr(`NBU_SERIAL_BUFFER_PORT0_OFF, d);
          wr(`NBU_SCON0_OFF, i[0] ? 8'h98 : 8'h90);
        end
      join
      chk(f, {1'b1, ~i[0], d, 1'b0});
      rdc(`NBU_SCON0_OFF, 8'h02, 8'h02);
    end
    wr(`NBU_SCON1_OFF, 8'hd8);
    fork
      i_remote1.capture_frame(f);
      wr(`NBU_SERIAL_BUFFER_PORT1_OFF, 8'h96);
    join
    chk(f, {2'b11, 8'h96, 1'b0});
    wr(`NBU_SCON0_OFF, 8'h90);
    i_remote0.send_frame(8'h3c, 1'b1, 1'b1, 1'b1);
    rdc(`NBU_SERIAL_BUFFER_PORT0_OFF, 8'hff, 8'h3c);
    rdc(`NBU_SCON0_OFF, 8'h05, 8'h05);
    i_remote0.send_frame(8'h55, 1'b0, 1'b0, 1'b0);
    rdc(`NBU_SERIAL_BUFFER_PORT0_OFF, 8'hff, 8'h3c);
    rdc(`NBU_SCON0_OFF, 8'h05, 8'h05);
    wr(`NBU_POWER_CONTROL_REG_OFF, 8'he0);
    rdc(`NBU_SCON0_OFF, 8'h80, 8'h80);
    wr(`NBU_SCON0_OFF, 8'h90);
    i_remote0.send_frame(8'h81, 1'b0, 1'b1, 1'b0);
    rdc(`NBU_SCON0_OFF, 8'h81, 8'h81);
    wr(`NBU_SCON0_OFF, 8'h10);
    rdc(`NBU_SCON0_OFF, 8'h80, 8'h00);
    wr(`NBU_POWER_CONTROL_REG_OFF, 8'ha0);
    rdc(`NBU_SCON0_OFF, 8'h80, 8'h80);
    for (int i = 0; i < 4; i++) begin
      wr(`NBU_SCON0_OFF, 8'hb0);
      i_remote0.send_frame(adr[i], nin[i], 1'b1, 1'b0);
      rdc(`NBU_SCON0_OFF, 8'h01, {7'h0, hit[i]});
    end
    wr(`NBU_SCON1_OFF, 8'hf0);
    i_remote1.send_frame(8'h13, 1'b1, 1'b1, 1'b0);
    rdc(`NBU_SERIAL_BUFFER_PORT1_OFF, 8'hff, 8'h13);
    rdc(`NBU_SCON1_OFF, 8'h05, 8'h05);
    // Port 0 on timer 2, port 1 on the slow prescaler, both at once
    wr(`NBU_POWER_CONTROL_REG_OFF, 8'h90);
    wr(`NBU_SCON0_OFF, 8'hc0);
    wr(`NBU_SCON1_OFF, 8'h88);
    fork
      i_remote0.capture_frame(f);
      i_remote1.capture_frame(fb);
      begin
        wr(`NBU_SERIAL_BUFFER_PORT0_OFF, 8'h69);
        wr(`NBU_SERIAL_BUFFER_PORT1_OFF, 8'h4b);
      end
    join
    chk(f, {2'b10, 8'h69, 1'b0});
    chk(fb, {2'b11, 8'h4b, 1'b0});
    end_sim();
  end
endmodule
`default_nettype wire
